/* design/t8c_timer.sv */
// 8-bit up/down timer with one compare unit behind an AXI4-Lite slave.
// Assumes one clock; the count pin is asynchronous, ack and enable inputs are
// driven by logic on clk.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module t8c_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [t8c_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [t8c_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [t8c_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [t8c_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Count pin and processor side
    input wire logic external_count_input,
    input wire logic global_irq_enable,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    // Outputs
    output logic compare_output_pin,
    output logic irq_compare,
    output logic irq_overflow
);
    // Write channel state
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [t8c_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [t8c_pkg::CNT_W-1:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d, force_q, force_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    // Read channel state
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [t8c_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    // Timer state
    t8c_pkg::t8c_ctrl_t ctrl_q, ctrl_d;
    logic [t8c_pkg::CNT_W-1:0] cnt_q, cnt_d, cmp_act_q, cmp_act_d, cmp_buf_q, cmp_buf_d;
    logic [1:0] mask_q, mask_d;
    logic down_q, down_d, block_q, block_d;
    logic ovf_flag_q, ovf_flag_d, cmp_flag_q, cmp_flag_d;
    logic wave_q, wave_d, pin_q, pin_d;
    logic irq_cmp_q, irq_cmp_d, irq_ovf_q, irq_ovf_d;
    logic [t8c_pkg::PRE_W-1:0] pre_q, pre_d;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    // Decoded strobes
    logic wr_fire, wr_map, wr_ctrl, wr_count, wr_cmp, wr_flag, wr_mask;
    logic tick, match, at_max, at_bottom, pwm, cmp_set, ovf_set, buf_load, force_evt;
    logic [t8c_pkg::ADDR_W-1:0] aw_word, ar_word;

    // Word-aligned addresses
    assign aw_word = {awaddr_q[t8c_pkg::ADDR_W-1:2], 2'h0};
    assign ar_word = {s_axi_araddr[t8c_pkg::ADDR_W-1:2], 2'h0};

    // Write decode, lane 0 carries the byte
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_map = (aw_word == t8c_pkg::OFF_CTRL) || (aw_word == t8c_pkg::OFF_COUNT) ||
        (aw_word == t8c_pkg::OFF_COMPARE) || (aw_word == t8c_pkg::OFF_FLAG) ||
        (aw_word == t8c_pkg::OFF_MASK);
    assign wr_ctrl = wr_fire && wlane_q && (aw_word == t8c_pkg::OFF_CTRL);
    assign wr_count = wr_fire && wlane_q && (aw_word == t8c_pkg::OFF_COUNT);
    assign wr_cmp = wr_fire && wlane_q && (aw_word == t8c_pkg::OFF_COMPARE);
    assign wr_flag = wr_fire && wlane_q && (aw_word == t8c_pkg::OFF_FLAG);
    assign wr_mask = wr_fire && wlane_q && (aw_word == t8c_pkg::OFF_MASK);

    // AXI write channel next state
    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awaddr_d = awaddr_q;
        wbyte_d = wbyte_q;
        wlane_d = wlane_q;
        force_d = force_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && awready_q) begin
            aw_hold_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_hold_d = 1'b1;
            wbyte_d = s_axi_wdata[t8c_pkg::CNT_W-1:0];
            wlane_d = s_axi_wstrb[0];
            force_d = s_axi_wdata[t8c_pkg::CNT_W-1];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_map ? t8c_pkg::RESP_OKAY : t8c_pkg::RESP_SLVERR;
        end
        awready_d = !aw_hold_d;
        wready_d = !w_hold_d;
    end

    // AXI write channel registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wbyte_q <= '0;
            wlane_q <= 1'b0;
            force_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= t8c_pkg::RESP_OKAY;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awaddr_q <= awaddr_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            force_q <= force_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // AXI read channel next state, reads have no side effects
    always_comb begin
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d = '0;
            rresp_d = t8c_pkg::RESP_OKAY;
            unique case (ar_word)
                t8c_pkg::OFF_CTRL: rdata_d[t8c_pkg::CNT_W-2:0] = ctrl_q[t8c_pkg::CNT_W-2:0];
                t8c_pkg::OFF_COUNT: rdata_d[t8c_pkg::CNT_W-1:0] = cnt_q;
                t8c_pkg::OFF_COMPARE: rdata_d[t8c_pkg::CNT_W-1:0] = pwm ? cmp_buf_q : cmp_act_q;
                t8c_pkg::OFF_FLAG: begin
                    rdata_d[t8c_pkg::FLG_OVF] = ovf_flag_q;
                    rdata_d[t8c_pkg::FLG_CMP] = cmp_flag_q;
                end
                t8c_pkg::OFF_MASK: rdata_d[1:0] = mask_q;
                default: rresp_d = t8c_pkg::RESP_SLVERR;
            endcase
        end
        arready_d = !rvalid_d;
    end

    // AXI read channel registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= t8c_pkg::RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Count pin synchroniser, third stage for edge detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= external_count_input;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // Free-running prescaler
    assign pre_d = pre_q + 10'h001;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_d;
        end
    end

    always_comb begin
        unique case (ctrl_q.src)
            t8c_pkg::CS_STOP: tick = 1'b0;
            t8c_pkg::CS_DIV1: tick = 1'b1;
            t8c_pkg::CS_DIV8: tick = (pre_q & t8c_pkg::PRE_M8) == t8c_pkg::PRE_M8;
            t8c_pkg::CS_DIV64: tick = (pre_q & t8c_pkg::PRE_M64) == t8c_pkg::PRE_M64;
            t8c_pkg::CS_DIV256: tick = (pre_q & t8c_pkg::PRE_M256) == t8c_pkg::PRE_M256;
            t8c_pkg::CS_DIV1024: tick = (pre_q & t8c_pkg::PRE_M1024) == t8c_pkg::PRE_M1024;
            t8c_pkg::CS_EXT_FALL: tick = ext_s3_q && !ext_s2_q;
            t8c_pkg::CS_EXT_RISE: tick = !ext_s3_q && ext_s2_q;
        endcase
    end

    assign at_bottom = cnt_q == t8c_pkg::CNT_BOTTOM;
    assign at_max = cnt_q == t8c_pkg::CNT_MAX;
    assign match = cnt_q == cmp_act_q;
    assign pwm = (ctrl_q.mode == t8c_pkg::WGM_PHASE) || (ctrl_q.mode == t8c_pkg::WGM_FAST);
    // load at top turn only (count at max)
    assign buf_load = pwm && tick && at_max;
    assign cmp_set = tick && match && !block_q;
    assign ovf_set = tick && ((ctrl_q.mode == t8c_pkg::WGM_PHASE) ? (down_q && at_bottom) :
        at_max);
    assign force_evt = wr_ctrl && force_q && !pwm;

    // Counter, direction and control next state
    always_comb begin
        cnt_d = cnt_q;
        down_d = 1'b0;
        ctrl_d = ctrl_q;
        if (tick) begin
            unique case (ctrl_q.mode)
                t8c_pkg::WGM_PHASE: begin
                    down_d = down_q;
                    if (!down_q && at_max) begin
                        down_d = 1'b1;
                    end else if (down_q && at_bottom) begin
                        down_d = 1'b0;
                    end
                    cnt_d = down_d ? cnt_q - 8'h01 : cnt_q + 8'h01;
                end
                t8c_pkg::WGM_CTC: cnt_d = match ? t8c_pkg::CNT_BOTTOM : cnt_q + 8'h01;
                t8c_pkg::WGM_NORMAL,
                t8c_pkg::WGM_FAST: cnt_d = cnt_q + 8'h01;
            endcase
        end else if (ctrl_q.mode == t8c_pkg::WGM_PHASE) begin
            down_d = down_q;
        end
        if (wr_count) begin
            cnt_d = wbyte_q;
        end
        if (wr_ctrl) begin
            ctrl_d = t8c_pkg::t8c_ctrl_t'(wbyte_q);
            ctrl_d.force_cmp = 1'b0;
        end
    end

    // Compare, flags, mask and block next state
    always_comb begin
        cmp_buf_d = cmp_buf_q;
        cmp_act_d = cmp_act_q;
        mask_d = mask_q;
        block_d = wr_count ? 1'b1 : (tick ? 1'b0 : block_q);
        if (wr_cmp) begin
            cmp_buf_d = wbyte_q;
            if (!pwm) begin
                cmp_act_d = wbyte_q;
            end
        end
        if (buf_load) begin
            cmp_act_d = cmp_buf_q;
        end
        if (wr_mask) begin
            mask_d = wbyte_q[1:0];
        end
        // service or write-one clears, set wins
        ovf_flag_d = (ovf_flag_q && !overflow_irq_ack &&
            !(wr_flag && wbyte_q[t8c_pkg::FLG_OVF])) || ovf_set;
        cmp_flag_d = (cmp_flag_q && !compare_irq_ack &&
            !(wr_flag && wbyte_q[t8c_pkg::FLG_CMP])) || cmp_set;
        irq_cmp_d = cmp_flag_q && mask_q[t8c_pkg::FLG_CMP] && global_irq_enable;
        irq_ovf_d = ovf_flag_q && mask_q[t8c_pkg::FLG_OVF] && global_irq_enable;
    end

    always_comb begin
        wave_d = wave_q;
        unique case (ctrl_q.mode)
            t8c_pkg::WGM_NORMAL,
            t8c_pkg::WGM_CTC: begin
                if (cmp_set || force_evt) begin
                    unique case (ctrl_q.action)
                        t8c_pkg::ACT_NONE: wave_d = wave_q;
                        t8c_pkg::ACT_TOGGLE: wave_d = !wave_q;
                        t8c_pkg::ACT_CLEAR: wave_d = 1'b0;
                        t8c_pkg::ACT_SET: wave_d = 1'b1;
                    endcase
                end
            end
            t8c_pkg::WGM_FAST: begin
                if (ctrl_q.action[1]) begin
                    if (cmp_set) begin
                        wave_d = ctrl_q.action[0];
                    end
                    if (tick && at_max) begin
                        wave_d = !ctrl_q.action[0];
                    end
                end
            end
            t8c_pkg::WGM_PHASE: begin
                if (ctrl_q.action[1] && cmp_set) begin
                    wave_d = down_q ^ ctrl_q.action[0];
                end
            end
        endcase
        pin_d = (ctrl_q.action != t8c_pkg::ACT_NONE) ? wave_d : 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= t8c_pkg::t8c_ctrl_t'(t8c_pkg::CTRL_RST);
            cnt_q <= t8c_pkg::CNT_BOTTOM;
            cmp_act_q <= t8c_pkg::CNT_BOTTOM;
            cmp_buf_q <= t8c_pkg::CNT_BOTTOM;
            mask_q <= 2'h0;
            down_q <= 1'b0;
            block_q <= 1'b0;
            ovf_flag_q <= 1'b0;
            cmp_flag_q <= 1'b0;
            wave_q <= 1'b0;
            pin_q <= 1'b0;
            irq_cmp_q <= 1'b0;
            irq_ovf_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            cnt_q <= cnt_d;
            cmp_act_q <= cmp_act_d;
            cmp_buf_q <= cmp_buf_d;
            mask_q <= mask_d;
            down_q <= down_d;
            block_q <= block_d;
            ovf_flag_q <= ovf_flag_d;
            cmp_flag_q <= cmp_flag_d;
            wave_q <= wave_d;
            pin_q <= pin_d;
            irq_cmp_q <= irq_cmp_d;
            irq_ovf_q <= irq_ovf_d;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign compare_output_pin = pin_q;
    assign irq_compare = irq_cmp_q;
    assign irq_overflow = irq_ovf_q;

    // Checks on the timer core
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_stop_holds;
        (ctrl_q.src == t8c_pkg::CS_STOP) && !wr_count |=> cnt_q == $past(cnt_q);
    endproperty
    a_stop_holds: assert property (p_stop_holds)
        else $error("counter moved while stopped");

    property p_write_wins;
        wr_count |=> cnt_q == $past(wbyte_q);
    endproperty
    a_write_wins: assert property (p_write_wins)
        else $error("counter write lost");

    property p_step_one;
        tick && !wr_count && (ctrl_q.mode == t8c_pkg::WGM_NORMAL)
            |=> cnt_q == $past(cnt_q) + 8'h01;
    endproperty
    a_step_one: assert property (p_step_one)
        else $error("normal mode step not one");

    property p_cmp_flag;
        tick && match && !block_q |=> cmp_flag_q;
    endproperty
    a_cmp_flag: assert property (p_cmp_flag)
        else $error("compare flag not set after match tick");

    property p_block;
        block_q && !cmp_flag_q |=> !cmp_flag_q;
    endproperty
    a_block: assert property (p_block)
        else $error("compare flag set while blocked");

    property p_irq;
        cmp_flag_q && mask_q[t8c_pkg::FLG_CMP] && global_irq_enable ##1 cmp_flag_q
            |-> irq_compare;
    endproperty
    a_irq: assert property (p_irq)
        else $error("compare request missing");

    property p_ack;
        compare_irq_ack && !cmp_set |=> !cmp_flag_q ##1 !irq_compare;
    endproperty
    a_ack: assert property (p_ack)
        else $error("service did not clear compare flag");

    property p_ovf;
        tick && !wr_count && at_max && (ctrl_q.mode == t8c_pkg::WGM_NORMAL)
            |=> ovf_flag_q && (cnt_q == t8c_pkg::CNT_BOTTOM);
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow at max not flagged");

    property p_buffered;
        pwm && !buf_load |=> cmp_act_q == $past(cmp_act_q);
    endproperty
    a_buffered: assert property (p_buffered)
        else $error("active compare changed off the top");
endmodule

`default_nettype wire

/* design/t8c_pkg.sv */
// Shared constants and types for the 8-bit timer with one compare unit.
// Assumes an AXI4-Lite master with 32-bit data and a byte-addressed map.
package t8c_pkg;
    // Bus geometry, counter and prescaler widths
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned PRE_W = 10;

    // Register byte offsets
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_COUNT = 6'h04;
    localparam logic [5:0] OFF_COMPARE = 6'h08;
    localparam logic [5:0] OFF_FLAG = 6'h0c;
    localparam logic [5:0] OFF_MASK = 6'h10;

    // Flag and mask bit positions
    localparam int unsigned FLG_OVF = 0;
    localparam int unsigned FLG_CMP = 1;

    // Extreme counter values and control reset value
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Clock source select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // Prescaler tap masks (tick when all masked bits are one)
    localparam logic [9:0] PRE_M8 = 10'h007;
    localparam logic [9:0] PRE_M64 = 10'h03f;
    localparam logic [9:0] PRE_M256 = 10'h0ff;
    localparam logic [9:0] PRE_M1024 = 10'h3ff;

    // Compare output actions
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WGM_NORMAL = 2'h0,
        WGM_PHASE = 2'h1,
        WGM_CTC = 2'h2,
        WGM_FAST = 2'h3
    } t8c_wgm_t;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic force_cmp;
        logic [1:0] action;
        t8c_wgm_t mode;
        logic [2:0] src;
    } t8c_ctrl_t;
endpackage

/* bench/tb_timer8_counter_compare.sv */
// Self-checking bench for the 8-bit timer with one compare unit.
// Assumes the timer alone on its AXI4-Lite port, driven from this bench.
`timescale 1ns/1ps
`default_nettype none
module tb_timer8_counter_compare;
    logic clk, reset_n, awv, wv, bry, arv, rry, pin, gie, cack, oack;
    logic awr, wr, bv, arr, rv, opin, irqc, irqo;
    logic [5:0] awa, ara;
    logic [31:0] wd, rd, val;
    logic [3:0] ws;
    logic [1:0] br, rr, resp;
    int errors, total_checks, seed, n, w, mdl[5];
    // Timer under test
    t8c_timer t8c_timer_inst (.clk(clk), .reset_n(reset_n), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .external_count_input(pin),
        .global_irq_enable(gie), .compare_irq_ack(cack), .overflow_irq_ack(oack),
        .compare_output_pin(opin), .irq_compare(irqc), .irq_overflow(irqo));
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic tally_and_finish();
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Bus write, address and data offered together
    task automatic axw(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!(bv && bry));
        resp = br;
        bry <= 1'b0;
    endtask
    // Bus read
    task automatic axr(input logic [5:0] a);
        @(posedge clk);
        arv <= 1'b1; ara <= a; rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!(rv && rry));
        val = rd;
        resp = rr;
        rry <= 1'b0;
    endtask
    // Read and compare data and response
    task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] exp,
                         input logic [1:0] er);
        axr(a);
        chk(nm, val, exp);
        chk("rresp", 32'(resp), 32'(er));
    endtask
    // Hang guard
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        seed = 27654;
        {awv, wv, bry, arv, rry, pin, gie, cack, oack} = '0;
        awa = '0; ara = '0; wd = '0; ws = 4'hf; reset_n = 1'b0;
        mdl = '{0, 0, 0, 0, 0};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values
        for (int i = 0; i < 5; i++) rdchk("reset", 6'(4 * i), 32'(mdl[i]), 2'h0);
        // Random values, stopped timer must hold them
        repeat (4) begin
            w = $random(seed);
            mdl[1] = w & 255;
            axw(t8c_pkg::OFF_COUNT, 32'(w));
            w = $random(seed);
            mdl[2] = w & 255;
            axw(t8c_pkg::OFF_COMPARE, 32'(w));
            repeat (20) @(posedge clk);
            rdchk("count", t8c_pkg::OFF_COUNT, 32'(mdl[1]), 2'h0);
            rdchk("compare", t8c_pkg::OFF_COMPARE, 32'(mdl[2]), 2'h0);
        end
        // Unmapped place
        axw(6'h14, 32'h0000_00ff);
        chk("bresp", 32'(resp), 32'(t8c_pkg::RESP_SLVERR));
        rdchk("unmapped", 6'h14, 32'h0, t8c_pkg::RESP_SLVERR);
        // Control readback, strobe reads zero
        axw(t8c_pkg::OFF_CTRL, 32'h0000_00f8);
        rdchk("ctrl", t8c_pkg::OFF_CTRL, 32'h0000_0078, 2'h0);
        // Pin edges counted in both edge modes
        for (int c = 6; c < 8; c++) begin
            axw(t8c_pkg::OFF_CTRL, 32'h0);
            axw(t8c_pkg::OFF_COUNT, 32'h0);
            axw(t8c_pkg::OFF_CTRL, 32'(c));
            n = 1 + ($random(seed) & 15);
            repeat (n) begin
                repeat (4) @(posedge clk);
                pin <= 1'b1;
                repeat (4) @(posedge clk);
                pin <= 1'b0;
            end
            repeat (6) @(posedge clk);
            rdchk("ext count", t8c_pkg::OFF_COUNT, 32'(n), 2'h0);
        end
        // Wrap past compare and max, then interrupts
        axw(t8c_pkg::OFF_CTRL, 32'h0);
        axw(t8c_pkg::OFF_FLAG, 32'h3);
        axw(t8c_pkg::OFF_COUNT, 32'hf0);
        axw(t8c_pkg::OFF_COMPARE, 32'hf8);
        axw(t8c_pkg::OFF_MASK, 32'h3);
        axw(t8c_pkg::OFF_CTRL, 32'(t8c_pkg::CS_DIV1));
        repeat (30) @(posedge clk);
        axw(t8c_pkg::OFF_CTRL, 32'h0);
        rdchk("flags", t8c_pkg::OFF_FLAG, 32'h3, 2'h0);
        chk("irq cmp gated", 32'(irqc), 32'h0);
        gie <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq cmp", 32'(irqc), 32'h1);
        chk("irq ovf", 32'(irqo), 32'h1);
        axw(t8c_pkg::OFF_MASK, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq cmp masked", 32'(irqc), 32'h0);
        @(posedge clk);
        cack <= 1'b1;
        @(posedge clk);
        cack <= 1'b0;
        rdchk("flag ack", t8c_pkg::OFF_FLAG, 32'h1, 2'h0);
        axw(t8c_pkg::OFF_FLAG, 32'h1);
        rdchk("flag w1c", t8c_pkg::OFF_FLAG, 32'h0, 2'h0);
        chk("irq ovf clear", 32'(irqo), 32'h0);
        // Counter written equal to compare: first match blocked
        axw(t8c_pkg::OFF_COMPARE, 32'h40);
        axw(t8c_pkg::OFF_COUNT, 32'h40);
        axw(t8c_pkg::OFF_CTRL, 32'(t8c_pkg::CS_DIV1));
        repeat (30) @(posedge clk);
        axw(t8c_pkg::OFF_CTRL, 32'h0);
        rdchk("blocked", t8c_pkg::OFF_FLAG, 32'h0, 2'h0);
        // Forced match toggles the pin in normal mode
        axw(t8c_pkg::OFF_CTRL, 32'h0000_0020);
        axw(t8c_pkg::OFF_CTRL, 32'h0000_00a0);
        @(negedge clk);
        chk("force pin", 32'(opin), 32'h1);
        // Clear on match: count never passes compare, pin cleared
        n = 4 + ($random(seed) & 31);
        axw(t8c_pkg::OFF_COMPARE, 32'(n));
        axw(t8c_pkg::OFF_COUNT, 32'h0);
        axw(t8c_pkg::OFF_CTRL, 32'h0000_0051);
        repeat (60) @(posedge clk);
        @(negedge clk);
        chk("ctc pin", 32'(opin), 32'h0);
        axw(t8c_pkg::OFF_CTRL, 32'h0);
        axr(t8c_pkg::OFF_COUNT);
        chk("ctc top", 32'(val <= 32'(n)), 32'h1);
        rdchk("ctc flag", t8c_pkg::OFF_FLAG, 32'h2, 2'h0);
        // PWM writes land in the buffer, active kept
        axw(t8c_pkg::OFF_COMPARE, 32'h11);
        axw(t8c_pkg::OFF_CTRL, 32'h0000_0018);
        axw(t8c_pkg::OFF_COMPARE, 32'h22);
        rdchk("pwm buffer", t8c_pkg::OFF_COMPARE, 32'h22, 2'h0);
        axw(t8c_pkg::OFF_CTRL, 32'h0);
        rdchk("active kept", t8c_pkg::OFF_COMPARE, 32'h11, 2'h0);
        // Phase mode turns at max, loads buffer there, no overflow at max
        axw(t8c_pkg::OFF_COUNT, 32'hf8);
        axw(t8c_pkg::OFF_CTRL, 32'h0000_0009);
        repeat (30) @(posedge clk);
        axw(t8c_pkg::OFF_CTRL, 32'h0);
        axr(t8c_pkg::OFF_COUNT);
        chk("phase down", 32'(val >= 32'hc0 && val < 32'hff), 32'h1);
        rdchk("buffer loaded", t8c_pkg::OFF_COMPARE, 32'h22, 2'h0);
        rdchk("phase flags", t8c_pkg::OFF_FLAG, 32'h2, 2'h0);
        // Fast PWM: set at bottom, cleared on match
        axw(t8c_pkg::OFF_COMPARE, 32'h20);
        axw(t8c_pkg::OFF_COUNT, 32'hf8);
        axw(t8c_pkg::OFF_CTRL, 32'h0000_0059);
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk("fast pin set", 32'(opin), 32'h1);
        repeat (30) @(posedge clk);
        @(negedge clk);
        chk("fast pin clear", 32'(opin), 32'h0);
        axw(t8c_pkg::OFF_CTRL, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
